//--- design/cell_usage_map.sv
// maps configured cell count to evaluated tap pairs
`timescale 1ns/10ps
module cell_usage_map (
   // configuration
   input  wire logic [2:0] cellCount,
   // evaluated pairs, bit n is tap n+1 minus tap n
   output logic      [6:0] pairUsed
);
   // pairs outside the list are treated as shorted
   always_comb begin
      unique case (cellCount)
         3'h7:    pairUsed = 7'h7f;
         3'h6:    pairUsed = 7'h77;
         3'h5:    pairUsed = 7'h57;
         3'h4:    pairUsed = 7'h55;
         3'h3:    pairUsed = 7'h51;
         3'h2:    pairUsed = 7'h41;
         default: pairUsed = 7'h7f;              // 0,1 illegal: keep all
      endcase
   end
endmodule

//--- design/protection_fet_ctrl.sv
// protection fet drive, measurement sequencing and external ldo control
// Notes on behaviour
// - fewer than seven cells evaluate fixed tap pairs; others are shorted.
// - cell protections of unused inputs are switched off.
// - die overtemperature turns fets off and optionally powers off.
// - thermistor bias is on only during the temperature slot.
// - series body-diode mode may turn on the blocked driver.
// - body-diode decisions need current above the threshold.
// - discharge drive high unless blocked or an enabled fault.
// - forced-on commands apply only when configuration permits.
// - discharge off suspends both discharge overcurrent and short checks.
// - charge drive high unless blocked or an enabled fault.
// - overcurrent circuitry keeps running whatever the charge drive.
// - charge off pulls the pin low for 100 us, then releases.
// - masks select which faults autonomously control each driver.
// - reference ratio out of range raises alert or fault if enabled.
// - mux sequences cells, die sensor, thermistor, core rail, ground.
// - ldo stays disabled or enables on each exit from power-off.
// - ldo level setting selects one of five output voltages.
// - ldo enables at power-up without host traffic.
// - die above about 120 C disables ldo, optionally powers off.
// - ldo returns on its own once the die cools, if not off.
// - power-off clears registers; reload comes at next power-up.
`timescale 1ns/10ps
module protection_fet_ctrl
   import protector_pkg::*;
#(
   parameter int PULL_CYCLES = CHG_PULL_CYC,
   parameter int DIV_CYCLES  = LFO_DIV
) (
   // clock and reset
   input  wire logic                         clock,
   input  wire logic                         srst,
   // apb slave
   input  wire logic                         psel,
   input  wire logic                         penable,
   input  wire logic                         pwrite,
   input  wire logic [7:0]                   paddr,
   input  wire logic [31:0]                  pwdata,
   output logic      [31:0]                  prdata,
   output logic                              pready,
   output logic                              pslverr,
   // comparator and fault flags from the analog front end
   input  wire logic [protector_pkg::NFAULT-1:0] faultRaw,
   input  wire logic [6:0]                   cellFaultRaw,
   input  wire logic                         dieOverTempRaw,
   input  wire logic                         ldoOverTempRaw,
   input  wire logic                         refRatioBadRaw,
   input  wire logic                         chargingRaw,
   input  wire logic                         dischargingRaw,
   input  wire logic                         bodyCurrentHighRaw,
   // otp strap at power-up
   input  wire logic                         otpLdoEnable,
   // fet drivers
   output logic                              discharge_fet_drive,
   output logic                              charge_fet_drive,
   output logic                              chargePullLow,
   output logic                              dischargeOcEnable,
   output logic                              chargeOcEnable,
   // measurement front end
   output logic      [3:0]                   muxSelect,
   output logic                              thermBiasOn,
   output logic      [6:0]                   cellProtEnable,
   // ldo and power state
   output logic                              external_ldo_output,
   output logic      [2:0]                   ldoLevel,
   output logic                              power_off_state
);
   localparam int NIN = NFAULT + 13;

   // next used cell pair after the current slot; die slot once none is left.
   // shorted pairs are never visited, so no time is spent measuring a
   // pair whose protections are switched off anyway
   function automatic logic [3:0] next_used_pair(input logic [3:0] cur,
                                                 input logic [6:0] used);
      logic [3:0] pick;
      pick = 4'h7;
      for (int i = 6; i >= 1; i--) begin
         if (i > int'(cur) && used[i]) begin
            pick = 4'(i);
         end
      end
      return pick;
   endfunction

   // true when any fault that the mask hands to a driver is present
   function automatic logic any_enabled(input logic [NFAULT-1:0] flags,
                                        input logic [NFAULT-1:0] mask);
      return |(flags & mask);
   endfunction

   // two-flop synchroniser for every analog flag
   logic [NIN-1:0] syncA, syncB, rawAll;
   assign rawAll = {faultRaw, cellFaultRaw, dieOverTempRaw, ldoOverTempRaw,
                    refRatioBadRaw, chargingRaw, dischargingRaw,
                    bodyCurrentHighRaw};
   always_ff @(posedge clock) begin
      if (srst) begin
         syncA <= '0;
         syncB <= '0;
      end else begin
         syncA <= rawAll;
         syncB <= syncA;
      end
   end

   logic [NFAULT-1:0] fault;
   logic [6:0]        cellFault;
   logic              dieHot, ldoHot, refBad, charging, discharging;
   logic              bodyHigh;
   assign {fault, cellFault, dieHot, ldoHot, refBad, charging, discharging,
           bodyHigh} = syncB;

   // low-frequency tick: fet drives and mux slot only update at this rate
   logic [15:0] divCount;
   logic        lfTick;
   always_ff @(posedge clock) begin
      if (srst || lfTick) divCount <= '0;
      else                divCount <= divCount + 16'h0001;
   end
   assign lfTick = (divCount == 16'(DIV_CYCLES - 1));

   // configuration registers, cleared by power-off as well as reset
   logic [2:0]        cellCount;
   logic [4:0]        fetCfg;
   logic [NFAULT-1:0] autoDsg, autoChg;
   logic [3:0]        cmd;
   logic [4:0]        ldoCfg;
   logic              wrEn, rdEn, mapped;
   logic              clearAll;
   assign wrEn = psel && penable && pwrite;
   assign rdEn = psel && penable && !pwrite;
   assign clearAll = srst || power_off_state;
   always_ff @(posedge clock) begin
      if (clearAll) begin
         cellCount <= CELLCFG_RST;
         fetCfg    <= FETCFG_RST;
         autoDsg   <= AUTODSG_RST;
         autoChg   <= AUTOCHG_RST;
         cmd       <= '0;
         ldoCfg    <= LDOCFG_RST;
      end else if (wrEn) begin
         unique case (paddr)
            OFS_CELLCFG: cellCount <= pwdata[2:0];
            OFS_FETCFG:  fetCfg    <= pwdata[4:0];
            OFS_AUTODSG: autoDsg   <= pwdata[NFAULT-1:0];
            OFS_AUTOCHG: autoChg   <= pwdata[NFAULT-1:0];
            OFS_CMD:     cmd       <= pwdata[3:0];
            OFS_LDOCFG:  ldoCfg    <= pwdata[4:0];
            default: ;
         endcase
      end
   end

   // cell usage map and protection masking
   logic [6:0] pairUsed;
   cell_usage_map u_map (
      .cellCount (cellCount),
      .pairUsed  (pairUsed)
   );
   assign cellProtEnable = pairUsed;
   logic cellUvOv;
   assign cellUvOv = |(cellFault & pairUsed);

   // reference ratio diagnostic feeds fault bit when enabled
   logic [NFAULT-1:0] faultEff;
   always_comb begin
      faultEff = fault;
      faultEff[F_UV] = fault[F_UV] & cellUvOv;
      faultEff[F_OV] = fault[F_OV] & cellUvOv;
      faultEff[F_REF] = refBad & fetCfg[FC_REFDIAG];
   end

   // measurement mux sequencer, one slot per tick
   // order: used cell pairs, die sensor, thermistor, core rail, ground.
   // the bottom pair is always used, so slot 0 needs no skip logic
   logic [3:0] slot;
   always_ff @(posedge clock) begin
      if (srst) begin
         slot <= '0;
      end else if (lfTick) begin
         if (slot == 4'(MUX_SLOTS - 1)) begin
            slot <= '0;
         end else if (slot < 4'h7) begin
            slot <= next_used_pair(slot, pairUsed);
         end else begin
            slot <= slot + 4'h1;
         end
      end
   end
   assign muxSelect = slot;
   // bias only while the thermistor is sampled, saves pullup current
   assign thermBiasOn = (slot == MUX_THERM);

   // driver decisions, registered at tick rate
   logic blockDsg, blockChg, dsgFaultOn, chgFaultOn, bodyOk;
   // a fault only acts on a driver when its mask bit hands it control;
   // faults left out of a mask are still reported in the status word
   assign dsgFaultOn = any_enabled(faultEff, autoDsg);
   assign chgFaultOn = any_enabled(faultEff, autoChg);
   assign bodyOk = fetCfg[FC_SERIES] && fetCfg[FC_BODYDIO] && bodyHigh;
   assign blockDsg = cmd[CM_BLKDSG] || dieHot;
   assign blockChg = cmd[CM_BLKCHG] || dieHot;
   logic next_dsg, next_chg;
   always_comb begin
      next_dsg = !blockDsg && !dsgFaultOn;
      next_chg = !blockChg && !chgFaultOn;
      if (fetCfg[FC_FORCEOK] && cmd[CM_FRCDSG] && !dieHot)
         next_dsg = 1'b1;
      if (fetCfg[FC_FORCEOK] && cmd[CM_FRCCHG] && !dieHot)
         next_chg = 1'b1;
      if (bodyOk && charging && dsgFaultOn && next_chg && !dieHot)
         next_dsg = 1'b1;
      if (bodyOk && discharging && chgFaultOn && next_dsg && !dieHot)
         next_chg = 1'b1;
   end
   always_ff @(posedge clock) begin
      if (clearAll) begin
         discharge_fet_drive <= 1'b0;
         charge_fet_drive    <= 1'b0;
      end else if (lfTick) begin
         discharge_fet_drive <= next_dsg;
         charge_fet_drive    <= next_chg;
      end
   end
   // discharge overcurrent checks sleep with the fet to save power
   assign dischargeOcEnable = discharge_fet_drive;
   assign chargeOcEnable = 1'b1;

   // active pull-low window after charge turns off
   logic [15:0] pullCount;
   logic        chgPrev;
   always_ff @(posedge clock) begin
      if (srst) begin
         chgPrev   <= 1'b0;
         pullCount <= '0;
      end else begin
         chgPrev <= charge_fet_drive;
         if (chgPrev && !charge_fet_drive)
            pullCount <= 16'(PULL_CYCLES);
         else if (pullCount != 16'h0000)
            pullCount <= pullCount - 16'h0001;
      end
   end
   assign chargePullLow = (pullCount != 16'h0000);

   // power-off entry from die or ldo overtemperature when configured
   always_ff @(posedge clock) begin
      if (srst) power_off_state <= 1'b0;
      else if (dieHot && fetCfg[FC_DIEOFF]) power_off_state <= 1'b1;
      else if (ldoHot && ldoCfg[LC_OTOFF]) power_off_state <= 1'b1;
   end

   // otp strap caught after reset release, not under it
   logic ldoStrap;
   always_ff @(posedge clock) begin
      if (srst) ldoStrap <= 1'b0;
      else ldoStrap <= otpLdoEnable;
   end

   // ldo on without host traffic, off while hot, back once cool
   always_ff @(posedge clock) begin
      if (srst || power_off_state) external_ldo_output <= 1'b0;
      else external_ldo_output <= ldoStrap && ldoCfg[LC_ENABLE] && !ldoHot;
   end
   assign ldoLevel = ldoCfg[2:0];

   // apb read mux; unmapped address answers slverr
   always_comb begin
      mapped = 1'b1;
      prdata = '0;
      unique case (paddr)
         OFS_CELLCFG:  prdata[2:0] = cellCount;
         OFS_FETCFG:   prdata[4:0] = fetCfg;
         OFS_AUTODSG:  prdata[NFAULT-1:0] = autoDsg;
         OFS_AUTOCHG:  prdata[NFAULT-1:0] = autoChg;
         OFS_CMD:      prdata[3:0] = cmd;
         OFS_LDOCFG:   prdata[4:0] = ldoCfg;
         OFS_STATUS:   prdata = {8'h00, faultEff, slot, dieHot, ldoHot,
                                 external_ldo_output, chargePullLow,
                                 charge_fet_drive, discharge_fet_drive,
                                 power_off_state, refBad & fetCfg[FC_REFDIAG]};
         OFS_CELLMASK: prdata[6:0] = pairUsed;
         default:      mapped = 1'b0;
      endcase
      if (!rdEn) prdata = '0;
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !mapped;
endmodule

//--- inc/protector_pkg.sv
// shared constants for the protection fet and ldo controller
package protector_pkg;
   // apb register byte offsets
   localparam logic [7:0] OFS_CELLCFG  = 8'h00;
   localparam logic [7:0] OFS_FETCFG   = 8'h04;
   localparam logic [7:0] OFS_AUTODSG  = 8'h08;
   localparam logic [7:0] OFS_AUTOCHG  = 8'h0c;
   localparam logic [7:0] OFS_CMD      = 8'h10;
   localparam logic [7:0] OFS_LDOCFG   = 8'h14;
   localparam logic [7:0] OFS_STATUS   = 8'h18;
   localparam logic [7:0] OFS_CELLMASK = 8'h1c;
   // fetcfg field positions
   localparam int FC_SERIES   = 0;
   localparam int FC_BODYDIO  = 1;
   localparam int FC_FORCEOK  = 2;
   localparam int FC_DIEOFF   = 3;
   localparam int FC_REFDIAG  = 4;
   // cmd field positions
   localparam int CM_BLKDSG   = 0;
   localparam int CM_BLKCHG   = 1;
   localparam int CM_FRCDSG   = 2;
   localparam int CM_FRCCHG   = 3;
   // ldocfg field positions
   localparam int LC_LEVEL    = 0;
   localparam int LC_ENABLE   = 3;
   localparam int LC_OTOFF    = 4;
   // fault vector bit positions (same for both auto masks)
   localparam int F_UV   = 0;
   localparam int F_OV   = 1;
   localparam int F_OTD  = 2;
   localparam int F_UTD  = 3;
   localparam int F_OTC  = 4;
   localparam int F_UTC  = 5;
   localparam int F_DISCHARGE_OVERCURRENT_ONE = 6;
   localparam int F_DISCHARGE_OVERCURRENT_TWO = 7;
   localparam int F_SCD  = 8;
   localparam int F_OCC  = 9;
   localparam int F_DIAG = 10;
   localparam int F_REF  = 11;
   localparam int NFAULT = 12;
   // reset values
   localparam logic [2:0]  CELLCFG_RST = 3'h7;
   localparam logic [4:0]  FETCFG_RST  = 5'h13;
   localparam logic [11:0] AUTODSG_RST = 12'hdcd;
   localparam logic [11:0] AUTOCHG_RST = 12'hf36;
   localparam logic [4:0]  LDOCFG_RST  = 5'h0b;
   // timing
   localparam int CLK_MHZ        = 100;
   localparam int CHG_PULL_US    = 100;
   localparam int CHG_PULL_CYC   = CHG_PULL_US * CLK_MHZ;
   localparam int LFO_DIV        = 3052;
   localparam int MUX_SLOTS      = 11;
   // mux slot codes
   typedef enum logic [3:0] {
      MUX_CELL0 = 4'h0, MUX_DIE = 4'h7, MUX_THERM = 4'h8,
      MUX_CORE = 4'h9, MUX_GND = 4'ha
   } mux_slot_t;
endpackage

//--- test/pack_fet_model.sv
// behavioural series pack fets and current sense flags
`timescale 1ns/10ps
module pack_fet_model (
   // clock and gate drives
   input wire logic clock,
   input wire logic dsgGate,
   input wire logic chgGate,
   // pack state chosen by the bench
   input wire logic chargerOn,
   input wire logic loadOn,
   // current flags back to the controller
   output logic     chargingRaw,
   output logic     dischargingRaw,
   output logic     bodyCurrentHighRaw
);
   // one closed gate still conducts through the other fet's body diode
   always_ff @(posedge clock) begin
      chargingRaw        <= chargerOn && chgGate;
      dischargingRaw     <= loadOn && dsgGate;
      bodyCurrentHighRaw <= (chargerOn && chgGate) || (loadOn && dsgGate);
   end
endmodule

//--- test/protection_fet_and_ldo_control_test.sv
// self-checking bench for the protection fet and ldo controller
`timescale 1ns/10ps
module protection_fet_and_ldo_control_test;
   import protector_pkg::*;
   localparam int PULL = 5;
   logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, penable = 1'b0;
   logic        pwrite = 1'b0, pready, pslverr, serr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rdat;
   logic [11:0] faultRaw = 12'h000;
   logic [6:0]  cellFaultRaw = 7'h7f, cellProtEnable;
   logic        dieOverTempRaw = 1'b0, ldoOverTempRaw = 1'b0;
   logic        refRatioBadRaw = 1'b0, otpLdoEnable = 1'b1;
   logic        chargingRaw, dischargingRaw, bodyCurrentHighRaw;
   logic        charger = 1'b0, load = 1'b0, thermBiasOn, chargePullLow;
   logic        discharge_fet_drive, charge_fet_drive, chargeOcEnable;
   logic        dischargeOcEnable, external_ldo_output, power_off_state;
   logic [3:0]  muxSelect, got;
   logic [2:0]  ldoLevel;
   logic [10:0] seen;
   int          failures = 0, total_checks = 0, n, k;
   // rows: {dsg, chg} expected, command, faults (bit 11 is ref ratio)
   logic [17:0] rows [16] = '{18'h30000, 18'h10001, 18'h20002, 18'h00004,
      18'h10008, 18'h20010, 18'h20020, 18'h10040, 18'h10080, 18'h00100,
      18'h20200, 18'h00400, 18'h00800, 18'h11000, 18'h22000, 18'h14001};
   logic [6:0]  maps [8] = '{7'h0, 7'h0, 7'h41, 7'h51, 7'h55, 7'h57,
      7'h77, 7'h7f};
   protection_fet_ctrl #(.PULL_CYCLES(PULL), .DIV_CYCLES(4)) uut (.*);
   pack_fet_model fets (.clock(clock), .dsgGate(discharge_fet_drive),
      .chgGate(charge_fet_drive), .chargerOn(charger), .loadOn(load),
      .chargingRaw(chargingRaw), .dischargingRaw(dischargingRaw),
      .bodyCurrentHighRaw(bodyCurrentHighRaw));
   always #5 clock = ~clock;
   task automatic check(input string nm, input logic [31:0] s, e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic complete_run;
      if (failures == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   // one apb transfer, entered just after a rising edge
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      for (k = 0; k < 50; k++) begin
         @(posedge clock);
         if (pready === 1'b1) break;
      end
      rdat = prdata;
      serr = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
      if (k == 50) check("pready", 32'h0, 32'h1);
      if (k == 50) complete_run;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      check("register", rdat, e);
   endtask
   // bounded wait for {dsg, chg, ldo, power-off}
   task automatic settle(input logic [3:0] e);
      for (k = 0; k < 60; k++) begin
         @(posedge clock);
         got = {discharge_fet_drive, charge_fet_drive, external_ldo_output,
                power_off_state};
         if (got === e) break;
      end
      check("outputs", 32'(got), 32'(e));
      if (k == 60) complete_run;
   endtask
   initial begin
      repeat (100000) @(posedge clock);
      failures++;
      complete_run;
   end
   initial begin
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      settle(4'b1110);
      rd(OFS_CELLCFG, 32'(CELLCFG_RST));
      rd(OFS_FETCFG, 32'(FETCFG_RST));
      rd(OFS_AUTODSG, 32'(AUTODSG_RST));
      rd(OFS_AUTOCHG, 32'(AUTOCHG_RST));
      rd(OFS_LDOCFG, 32'(LDOCFG_RST));
      apb(1'b1, OFS_CELLMASK, 32'h0);
      rd(OFS_CELLMASK, 32'h7f);
      apb(1'b0, 8'h20, 32'h0);
      check("slverr", 32'(serr), 32'h1);
      // at most one fault and one command per row
      for (n = 0; n < 16; n++) begin
         apb(1'b1, OFS_CMD, 32'(rows[n][15:12]));
         faultRaw       <= rows[n][11:0];
         refRatioBadRaw <= rows[n][11];
         settle({rows[n][17:16], 2'b10});
      end
      apb(1'b1, OFS_CMD, 32'h0);
      refRatioBadRaw <= 1'b0;
      // each legal cell count, cell faults only on shorted pairs
      for (n = 7; n >= 2; n--) begin
         apb(1'b1, OFS_CELLCFG, 32'(n));
         cellFaultRaw <= ~maps[n];
         faultRaw     <= 12'h003;
         repeat (20) @(posedge clock);
         seen = '0;
         repeat (200) begin
            @(posedge clock);
            seen[muxSelect] = 1'b1;
         end
         check("pairs", 32'(cellProtEnable), 32'(maps[n]));
         check("slots", 32'(seen), 32'({4'hf, maps[n]}));
         settle(4'b1110);
      end
      charger      <= 1'b1;
      apb(1'b1, OFS_CELLCFG, 32'h7);
      repeat (8) @(posedge clock);
      cellFaultRaw <= 7'h7f;
      faultRaw     <= 12'h001;
      repeat (12) @(posedge clock);
      settle(4'b1110);
      apb(1'b1, OFS_FETCFG, 32'h11);
      settle(4'b0110);
      apb(1'b1, OFS_FETCFG, 32'h15);
      apb(1'b1, OFS_CMD, 32'h4);
      settle(4'b1110);
      apb(1'b1, OFS_CMD, 32'h0);
      apb(1'b1, OFS_FETCFG, 32'h13);
      load     <= 1'b1;
      repeat (8) @(posedge clock);
      charger  <= 1'b0;
      faultRaw <= 12'h002;
      repeat (12) @(posedge clock);
      settle(4'b1110);
      load <= 1'b0;
      n = 0;
      repeat (60) begin
         @(posedge clock);
         if (chargePullLow === 1'b1) n++;
      end
      check("pull", 32'(n), 32'(PULL));
      faultRaw <= 12'h000;
      for (n = 0; n < 5; n++) begin
         apb(1'b1, OFS_LDOCFG, 32'(8 + n));
         check("level", 32'(ldoLevel), 32'(n));
      end
      ldoOverTempRaw <= 1'b1;
      settle(4'b1100);
      ldoOverTempRaw <= 1'b0;
      settle(4'b1110);
      dieOverTempRaw <= 1'b1;
      settle(4'b0010);
      apb(1'b1, OFS_FETCFG, 32'h1b);
      settle(4'b0001);
      // reset again with the strap off: ldo must stay down
      dieOverTempRaw <= 1'b0;
      otpLdoEnable   <= 1'b0;
      srst           <= 1'b1;
      repeat (20) @(posedge clock);
      srst <= 1'b0;
      settle(4'b1100);
      rd(OFS_CELLCFG, 32'(CELLCFG_RST));
      complete_run;
   end
endmodule

//--- test/protector_checker.sv
// assertion checker for the protection fet and ldo controller
`timescale 1ns/10ps
module protector_checker #(
   parameter int PULL_CYCLES = 5
) (
   // clock and reset
   input wire logic       clock,
   input wire logic       srst,
   // flags and outputs watched
   input wire logic       dieOverTempRaw,
   input wire logic       ldoOverTempRaw,
   input wire logic       discharge_fet_drive,
   input wire logic       charge_fet_drive,
   input wire logic       chargePullLow,
   input wire logic       dischargeOcEnable,
   input wire logic       chargeOcEnable,
   input wire logic [3:0] muxSelect,
   input wire logic       thermBiasOn,
   input wire logic [6:0] cellProtEnable,
   input wire logic       external_ldo_output,
   input wire logic       power_off_state
);
   int pullCnt;
   default clocking @(posedge clock); endclocking
   default disable iff (srst);
   // length of the running pull-low pulse
   always_ff @(posedge clock)
      if (srst || !chargePullLow) pullCnt <= 0;
      else pullCnt <= pullCnt + 1;
   AST_DSG_OC:
      assert property (dischargeOcEnable == discharge_fet_drive)
      else $error("discharge current checks not tied to drive");
   AST_CHG_OC:
      assert property (chargeOcEnable) else $error("charge checks stopped");
   AST_BIAS:
      assert property (thermBiasOn == (muxSelect == 4'h8))
      else $error("bias outside thermistor slot");
   AST_MUX:
      assert property (muxSelect <= 4'ha) else $error("mux slot out of range");
   AST_ENDS:
      assert property (!power_off_state |-> cellProtEnable[0]
         && cellProtEnable[6]) else $error("outer pairs not evaluated");
   AST_PULL_GO:
      assert property ($fell(charge_fet_drive) |-> ##[0:2] chargePullLow)
      else $error("no pull-low after charge off");
   AST_PULL_MAX:
      assert property (pullCnt <= PULL_CYCLES) else $error("pull too long");
   AST_POFF:
      assert property (power_off_state |=> power_off_state)
      else $error("power-off left without reset");
   AST_DIE:
      assert property (dieOverTempRaw [*8] |-> ##[0:8]
         !(discharge_fet_drive || charge_fet_drive))
      else $error("drives on while die hot");
   AST_LDO_HOT:
      assert property (ldoOverTempRaw [*8] |-> ##[0:8] !external_ldo_output)
      else $error("ldo on while hot");
   // main scenarios reached
   cover property ($fell(chargePullLow));
   cover property ($rose(power_off_state));
   cover property ($fell(external_ldo_output) ##[1:100] external_ldo_output);
endmodule
bind protection_fet_ctrl protector_checker #(.PULL_CYCLES(PULL_CYCLES))
   chk (.*);
